// ### hw/fgpm_pkg.sv
// fgpm_pkg: constants, tables and register map of the fine gain and power meter
package fgpm_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int SAMPLE_W     = 14;
  localparam int GAIN_CODE_W  = 4;
  localparam int AVG_CODE_W   = 3;
  localparam int LEVEL_W      = 4;
  localparam int GAIN_W       = 16;
  localparam int GAIN_FRAC    = 14;
  localparam int PROD_W       = 31;
  localparam int SQ_W         = 28;
  localparam int ACC_W        = 41;
  localparam int MEAN_W       = 27;
  localparam int CNT_W        = 14;
  localparam int SHIFT_W      = 5;
  localparam int NUM_THR      = 13;
  localparam int NUM_GAINS    = 13;

  //////////////////////////////////////////////////////////////////////////////
  // sample limits
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX = 14'sh1fff;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN = -14'sh2000;

  //////////////////////////////////////////////////////////////////////////////
  // gain codes, half a decibel per step, unity is 1.0 in q2.14
  localparam logic [GAIN_CODE_W-1:0] GAIN_CODE_RESET = 4'h0;
  localparam logic [GAIN_CODE_W-1:0] GAIN_CODE_MAX   = 4'hc;
  localparam logic [GAIN_W-1:0]      GAIN_UNITY      = 16'h4000;
  localparam logic [GAIN_W-1:0] GAIN_TABLE [NUM_GAINS] = '{
    16'h4000, 16'h43cb, 16'h47cf, 16'h4c10, 16'h5092, 16'h5558, 16'h5a67,
    16'h5fc2, 16'h656f, 16'h6b72, 16'h71d0, 16'h788e, 16'h7fb2
  };

  //////////////////////////////////////////////////////////////////////////////
  // averaging window: 1K samples shifted left by the code
  localparam logic [AVG_CODE_W-1:0] AVG_CODE_RESET = 3'h0;
  localparam logic [AVG_CODE_W-1:0] AVG_CODE_MAX   = 3'h4;
  localparam logic [SHIFT_W-1:0]    AVG_BASE_LOG2  = 5'h0a;
  localparam logic [CNT_W-1:0]      AVG_BASE_LAST  = 14'h03ff;

  //////////////////////////////////////////////////////////////////////////////
  // mean square thresholds; 0 dBFS is the mean square of a full scale sine
  // edges: -12.5 .. -1.5 dBFS in 1 dB steps, then 0 dBFS
  localparam logic [MEAN_W-1:0] THR_TABLE [NUM_THR] = '{
    27'h01ccacd, 27'h0243f26, 27'h02da1ad, 27'h0397283, 27'h0485285,
    27'h05b0c45, 27'h0729f5a, 27'h0904d12, 27'h0b5aa0d, 27'h0e4b3c4,
    27'h11feb29, 27'h16a77e6, 27'h2000000
  };
  localparam logic [LEVEL_W-1:0] LEVEL_FLOOR = 4'h1;
  localparam logic [LEVEL_W-1:0] LEVEL_OFF   = 4'h0;

  //////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam int           ADDR_W       = 8;
  localparam logic [7:0]   ADDR_CTRL    = 8'h00;
  localparam logic [7:0]   ADDR_STATUS  = 8'h04;
  localparam logic [7:0]   ADDR_MEAN    = 8'h08;
  localparam logic [7:0]   ADDR_COUNT   = 8'h0c;
  localparam int           CTRL_GAIN_LSB = 0;
  localparam int           CTRL_AVG_LSB  = 4;
  localparam int           CTRL_EN_BIT   = 8;
  localparam int           STAT_EN_BIT   = 8;
  localparam logic [1:0]   HTRANS_NONSEQ = 2'h2;
  localparam logic         HRESP_OKAY    = 1'h0;

endpackage : fgpm_pkg

// ### hw/fgpm_gain_rom.sv
// fgpm_gain_rom: gain factor lookup with registered read data
module fgpm_gain_rom
  import fgpm_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic [GAIN_CODE_W-1:0] gain_code,
  output logic      [GAIN_W-1:0]      gain_factor
);

  logic [GAIN_W-1:0] factor_next;

  // codes past the top step are held at the top step
  always_comb begin
    if (gain_code > GAIN_CODE_MAX) begin
      factor_next = GAIN_TABLE[GAIN_CODE_MAX];
    end else begin
      factor_next = GAIN_TABLE[gain_code];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      gain_factor <= GAIN_UNITY;
    end else begin
      gain_factor <= factor_next;
    end
  end

endmodule : fgpm_gain_rom

// ### hw/fgpm_top.sv
// fgpm_top: fine gain stage, power meter and its ahb-lite register slave
//
// Function
// (RL1) gain is code times half a decibel, codes 0000 to 1100; software avoids higher codes
// (RL2) gain code resets to 0000, no gain, until software writes another
// (RL3) output codes grow by gain factor, shrinking full scale from 2.00 to 1.00 Vpp
// (RL4) power is averaged over a programmable number of consecutive samples, about 1 dB coarse
// (RL5) power level pins carry the estimate only while the meter is enabled
// (RL6) level 0001 below -12.5 dBFS, 1 dB bands up to 1101, then 1110
// (RL7) window length comes from the 3-bit averaging length code
// (RL8) averaging codes 000 to 100 select 1K, 2K, 4K, 8K, 16K samples
// (RL9) mean of squares versus full scale, pins updated and held per completed window
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
module fgpm_top
  import fgpm_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       srst,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic                       hready,
  input  wire logic [31:0]                hwdata,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic signed [SAMPLE_W-1:0] sample_in,
  input  wire logic                       sample_valid,
  output logic signed [SAMPLE_W-1:0]      sample_out,
  output logic                            sample_out_valid,
  output logic      [LEVEL_W-1:0]         power_level
);

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // averaging codes past the top are held at 16K
  function automatic logic [AVG_CODE_W-1:0] avg_clamp(input logic [AVG_CODE_W-1:0] code);
    avg_clamp = (code > AVG_CODE_MAX) ? AVG_CODE_MAX : code; // RL8
  endfunction : avg_clamp

  // last count of a window
  function automatic logic [CNT_W-1:0] win_last(input logic [AVG_CODE_W-1:0] code);
    logic [AVG_CODE_W-1:0] c;
    c = avg_clamp(code);
    win_last = CNT_W'((32'(AVG_BASE_LAST) << c) | ((32'h1 << c) - 32'h1));
  endfunction : win_last

  // log2 of the window length
  function automatic logic [SHIFT_W-1:0] win_shift(input logic [AVG_CODE_W-1:0] code);
    logic [AVG_CODE_W-1:0] c;
    c = avg_clamp(code);
    win_shift = AVG_BASE_LOG2 + SHIFT_W'(c);
  endfunction : win_shift

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic                         wr_ph_reg;
  logic [ADDR_W-1:0]            addr_reg;
  logic [31:0]                  hrdata_reg;
  logic [31:0]                  rd_mux;
  logic                         bus_take;
  logic                         ctrl_wr;

  logic [GAIN_CODE_W-1:0]       gain_code_reg;
  logic [AVG_CODE_W-1:0]        avg_code_reg;
  logic                         meter_en_reg;

  logic [GAIN_W-1:0]            gain_factor;
  logic signed [PROD_W-1:0]     prod_full;
  logic signed [PROD_W-GAIN_FRAC-1:0] prod_scaled;
  logic signed [SAMPLE_W-1:0]   gained_next;
  logic signed [SAMPLE_W-1:0]   sample_out_reg;
  logic                         sample_out_valid_reg;

  logic [SQ_W-1:0]              sq_reg;
  logic                         sq_valid_reg;
  logic [ACC_W-1:0]             acc_reg;
  logic [ACC_W-1:0]             acc_sum;
  logic [CNT_W-1:0]             cnt_reg;
  logic [AVG_CODE_W-1:0]        avg_run_reg;
  logic                         win_restart;
  logic                         win_end;
  logic [MEAN_W-1:0]            mean_next;
  logic [MEAN_W-1:0]            mean_reg;
  logic [NUM_THR-1:0]           above_thr;
  logic [LEVEL_W-1:0]           level_next;
  logic [LEVEL_W-1:0]           level_reg;

  //////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states

  assign bus_take  = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == 2'h3);
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ph_reg <= 1'b0;
    end else begin
      wr_ph_reg <= bus_take & hwrite;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      addr_reg <= '0;
    end else begin
      addr_reg <= haddr[ADDR_W-1:0];
    end
  end

  // read data are captured in the address phase and stand in the data phase
  always_comb begin
    rd_mux = 32'h0;
    unique case (haddr[ADDR_W-1:0])
      ADDR_CTRL: begin
        rd_mux[CTRL_GAIN_LSB +: GAIN_CODE_W] = gain_code_reg;
        rd_mux[CTRL_AVG_LSB +: AVG_CODE_W]   = avg_code_reg;
        rd_mux[CTRL_EN_BIT]                  = meter_en_reg;
      end
      ADDR_STATUS: begin
        rd_mux[LEVEL_W-1:0] = level_reg;
        rd_mux[STAT_EN_BIT] = meter_en_reg;
      end
      ADDR_MEAN: begin
        rd_mux[MEAN_W-1:0] = mean_reg;
      end
      ADDR_COUNT: begin
        rd_mux[CNT_W-1:0] = cnt_reg;
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      hrdata_reg <= 32'h0;
    end else if (bus_take & ~hwrite) begin
      hrdata_reg <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control register

  assign ctrl_wr = wr_ph_reg & (addr_reg == ADDR_CTRL);

  always_ff @(posedge clock) begin
    if (srst) begin
      gain_code_reg <= GAIN_CODE_RESET; // RL2
    end else if (ctrl_wr) begin
      gain_code_reg <= hwdata[CTRL_GAIN_LSB +: GAIN_CODE_W]; // RL1
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      avg_code_reg <= AVG_CODE_RESET;
    end else if (ctrl_wr) begin
      avg_code_reg <= hwdata[CTRL_AVG_LSB +: AVG_CODE_W]; // RL7
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      meter_en_reg <= 1'b0;
    end else if (ctrl_wr) begin
      meter_en_reg <= hwdata[CTRL_EN_BIT]; // RL5
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fine gain stage

  fgpm_gain_rom fgpm_gain_rom_inst (
    .clock       (clock),
    .srst        (srst),
    .gain_code   (gain_code_reg),
    .gain_factor (gain_factor)
  );

  // q2.14 factor; saturation stands for the smaller full scale
  assign prod_full   = PROD_W'(sample_in) * PROD_W'($signed({1'b0, gain_factor})); // RL3
  assign prod_scaled = prod_full[PROD_W-1:GAIN_FRAC];

  always_comb begin
    if (prod_scaled > (PROD_W-GAIN_FRAC)'(SAMPLE_MAX)) begin
      gained_next = SAMPLE_MAX; // RL3
    end else if (prod_scaled < (PROD_W-GAIN_FRAC)'(SAMPLE_MIN)) begin
      gained_next = SAMPLE_MIN; // RL3
    end else begin
      gained_next = prod_scaled[SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sample_out_valid_reg <= 1'b0;
    end else begin
      sample_out_valid_reg <= sample_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sample_out_reg <= '0;
    end else if (sample_valid) begin
      sample_out_reg <= gained_next; // RL1
    end
  end

  assign sample_out       = sample_out_reg;
  assign sample_out_valid = sample_out_valid_reg;

  //////////////////////////////////////////////////////////////////////////////
  // power meter: squares, window accumulation

  always_ff @(posedge clock) begin
    if (srst) begin
      sq_valid_reg <= 1'b0;
    end else begin
      sq_valid_reg <= sample_out_valid_reg & meter_en_reg; // RL5
    end
  end

  // operands widened first so the square is not cut to the sample width
  always_ff @(posedge clock) begin
    if (srst) begin
      sq_reg <= '0;
    end else begin
      sq_reg <= SQ_W'(sample_out_reg) * SQ_W'(sample_out_reg); // RL9
    end
  end

  // a change of window length or a disabled meter starts a fresh window
  assign win_restart = ~meter_en_reg | (avg_run_reg != avg_code_reg);
  assign win_end     = ~win_restart & sq_valid_reg & (cnt_reg == win_last(avg_run_reg)); // RL8
  assign acc_sum     = acc_reg + ACC_W'(sq_reg);

  always_ff @(posedge clock) begin
    if (srst) begin
      avg_run_reg <= AVG_CODE_RESET;
    end else begin
      avg_run_reg <= avg_code_reg; // RL7
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      acc_reg <= '0;
    end else if (win_restart | win_end) begin
      acc_reg <= '0;
    end else if (sq_valid_reg) begin
      acc_reg <= acc_sum; // RL4
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_reg <= '0;
    end else if (win_restart | win_end) begin
      cnt_reg <= '0;
    end else if (sq_valid_reg) begin
      cnt_reg <= cnt_reg + 14'h0001; // RL4
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power meter: mean and level encoding

  assign mean_next = MEAN_W'(acc_sum >> win_shift(avg_run_reg)); // RL9

  genvar gi;
  generate
    for (gi = 0; gi < NUM_THR; gi++) begin : g_thr
      assign above_thr[gi] = (mean_next >= THR_TABLE[gi]); // RL6
    end
  endgenerate

  // thermometer count of crossed edges on top of the floor code
  always_comb begin
    level_next = LEVEL_FLOOR;
    for (int i = 0; i < NUM_THR; i++) begin
      level_next = level_next + LEVEL_W'(above_thr[i]); // RL6
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mean_reg <= '0;
    end else if (win_end) begin
      mean_reg <= mean_next; // RL9
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      level_reg <= LEVEL_OFF;
    end else if (~meter_en_reg) begin
      level_reg <= LEVEL_OFF; // RL5
    end else if (win_end) begin
      level_reg <= level_next; // RL9
    end
  end

  assign power_level = level_reg; // RL5

endmodule : fgpm_top

// ### bench/fgpm_props.sv
// fgpm_props: port checks of the fine gain and power meter
module fgpm_props
  import fgpm_pkg::*;
(
  input wire logic                       clock,
  input wire logic                       srst,
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic [31:0]                hrdata,
  input wire logic signed [SAMPLE_W-1:0] sample_in,
  input wire logic                       sample_valid,
  input wire logic signed [SAMPLE_W-1:0] sample_out,
  input wire logic                       sample_out_valid,
  input wire logic [LEVEL_W-1:0]         power_level
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic [10:0]        gap_reg;
  logic [LEVEL_W-1:0] last_reg;
  ////////////////////////////////////////
  // cycles since the level last moved
  always_ff @(posedge clock) begin
    last_reg <= power_level;
    if (srst || power_level != last_reg) begin
      gap_reg <= 11'h0;
    end else if (gap_reg != 11'h7ff) begin
      gap_reg <= gap_reg + 11'h1;
    end
  end
  sequence s_rd(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
  endsequence
  ////////////////////////////////////////
  chk_out_valid: assert property (sample_valid |=> sample_out_valid)
    else $error("sample strobe not echoed");
  chk_pos_gain: assert property (sample_valid && sample_in >= 0 |=> sample_out >= $past(sample_in))
    else $error("positive sample shrank");
  chk_neg_gain: assert property (sample_valid && sample_in < 0 |=> sample_out <= $past(sample_in))
    else $error("negative sample shrank");
  chk_out_hold: assert property (!sample_valid |=> $stable(sample_out) && !sample_out_valid)
    else $error("output moved without a sample");
  chk_level_max: assert property (power_level <= 4'he)
    else $error("level code above range");
  chk_level_gap: assert property (power_level != last_reg && last_reg != 0 && power_level != 0 |-> gap_reg >= 11'd1023)
    else $error("level moved inside a window");
  chk_status_mirror: assert property (s_rd(ADDR_STATUS) |=> hrdata[3:0] == $past(power_level))
    else $error("status level differs from pins");
  chk_floor_band: assert property (s_rd(ADDR_MEAN) ##0 power_level == LEVEL_FLOOR |=> hrdata[26:0] < THR_TABLE[0])
    else $error("floor level with large mean");
  chk_top_band: assert property (s_rd(ADDR_MEAN) ##0 power_level == 4'he |=> hrdata[26:0] >= THR_TABLE[12])
    else $error("top level with small mean");
endmodule : fgpm_props

bind fgpm_top fgpm_props fgpm_props_inst (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .sample_in(sample_in), .sample_valid(sample_valid),
  .sample_out(sample_out), .sample_out_valid(sample_out_valid), .power_level(power_level));

// ### bench/fgpm_level_reader.sv
// fgpm_level_reader: system logic latching the power level pins
module fgpm_level_reader
  import fgpm_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               srst,
  input  wire logic [LEVEL_W-1:0] power_level,
  output logic      [LEVEL_W-1:0] level_seen
);
  // keep the latest estimate seen on the pins
  always @(posedge clock) begin
    if (srst) begin
      level_seen <= LEVEL_OFF;
    end else begin
      level_seen <= power_level;
    end
  end
endmodule : fgpm_level_reader

// ### bench/fgpm_top_test.sv
// fgpm_top_test: self-checking bench of the fine gain and power meter
module fgpm_top_test
  import fgpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, srst, hsel, hwrite, hready, hreadyout, hresp, sample_valid, sample_out_valid, stream_on;
  logic [31:0]                haddr, hwdata, hrdata, q;
  logic [1:0]                 htrans;
  logic [2:0]                 hsize;
  logic signed [SAMPLE_W-1:0] sample_in, sample_out;
  logic [LEVEL_W-1:0]         power_level, level_seen;
  logic [15:0]                lf;
  int                         error_cnt, compares, cyc, amp, n, k, e;
  assign hready = hreadyout;
  fgpm_top fgpm_top_inst (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_in(sample_in), .sample_valid(sample_valid), .sample_out(sample_out),
    .sample_out_valid(sample_out_valid), .power_level(power_level));
  fgpm_level_reader fgpm_level_reader_inst (.clock(clock), .srst(srst), .power_level(power_level),
    .level_seen(level_seen));
  ////////////////////////////////////////
  function automatic logic [15:0] nxt(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nxt
  function automatic int gained(int s, int c);
    int p;
    p = (s * int'(GAIN_TABLE[c])) >>> 14;
    return p > 8191 ? 8191 : (p < -8192 ? -8192 : p);
  endfunction : gained
  function automatic int level_of(int m);
    int l;
    l = 1;
    for (int i = 0; i < NUM_THR; i++) begin
      if (m >= int'(THR_TABLE[i])) l++;
    end
    return l;
  endfunction : level_of
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
    check({30'h0, hreadyout, hresp}, 32'h2);
  endtask : bus
  task automatic complete_run();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // alternating full-wave stream for the meter, plus the hang limit
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (stream_on) begin
      sample_in <= (sample_in == amp) ? SAMPLE_W'(-amp) : SAMPLE_W'(amp);
      sample_valid <= 1'b1;
    end
    if (cyc == 60000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    {srst, hsel, hwrite, sample_valid, stream_on} = 5'h10;
    {haddr, hwdata, htrans, hsize, sample_in, amp} = '0;
    lf = 16'h3646;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    bus(1'b1, 8'h10, 32'hffff_ffff);
    bus(1'b1, ADDR_STATUS, 32'hffff_ffff);
    bus(1'b0, ADDR_CTRL, 32'h0);
    check(q, 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check(q, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    check(q, 32'h0);
    $display("reset test done");
    for (int c = 0; c <= 12; c++) begin
      bus(1'b1, ADDR_CTRL, 32'(c));
      bus(1'b0, ADDR_CTRL, 32'h0);
      check(q, 32'(c));
      for (k = 0; k < 4; k++) begin
        lf = nxt(lf);
        e = k == 0 ? 8191 : (k == 1 ? -8192 : int'($signed(lf[13:0])));
        sample_in <= SAMPLE_W'(e);
        sample_valid <= 1'b1;
        @(posedge clock);
        sample_valid <= 1'b0;
        #1 check(32'(sample_out), 32'(gained(e, c)));
        check({31'h0, sample_out_valid}, 32'h1);
        @(posedge clock);
      end
    end
    $display("gain test done");
    for (int i = 0; i < 7; i++) begin
      n = i < 5 ? i : 0;
      lf = nxt(lf);
      amp = i == 5 ? 100 : (i == 6 ? 8191 : int'(lf[12:0]));
      stream_on = 1'b1;
      bus(1'b1, ADDR_CTRL, 32'h0);
      repeat (2) @(negedge clock);
      check({28'h0, power_level}, 32'h0);
      @(posedge clock);
      bus(1'b1, ADDR_CTRL, 32'h100 | 32'(n << 4));
      k = 0;
      while (power_level === 4'h0 && k < 20000) begin
        @(negedge clock);
        k++;
      end
      @(posedge clock);
      check({31'h0, k >= (1024 << n) && k <= (1024 << n) + 4}, 32'h1);
      check({28'h0, power_level}, 32'(level_of(amp * amp)));
      bus(1'b0, ADDR_MEAN, 32'h0);
      check(q, 32'(amp * amp));
      check({28'h0, level_seen}, {28'h0, power_level});
      bus(1'b0, ADDR_STATUS, 32'h0);
      check(q, 32'h100 | 32'(level_of(amp * amp)));
      if (i == 5) begin
        amp = 8191;
        k = 0;
        while (power_level === 4'h1 && k < 2000) begin
          @(negedge clock);
          k++;
        end
        @(posedge clock);
        check({28'h0, power_level}, 32'he);
      end
    end
    stream_on = 1'b0;
    $display("meter test done");
    complete_run();
  end
endmodule : fgpm_top_test
